// File: rtl/tmrio_ch0.sv
// What this block does
// - Codes 0011/0111 compare, start 0/1, toggle on match; 0000/0100 disable.
// - Code 0001 starts low, 0101 starts high; both drive low on match.
// - Code 0010 starts low, 0110 starts high; both drive high on match.
// - Field A code 10xx captures from channel 0 pin A.
// - Code 1000 captures the counter on the rising capture edge.
// - Code 1001 captures the counter on the falling capture edge.
// - Codes 101x capture the counter on both edges.
// - Codes 11xx take the trigger from channel 1 count clock.
// - In that mode every channel 1 count up or down captures.
// - With A buffer enabled, register C gets no capture or compare.
//
// Design decisions made here: the address map and the APB register port.
module tmrio_ch0
  import tmrio_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire tmrio_apb_req_t    apb,
  output logic [DATA_W-1:0]      prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [CNT_W-1:0]  counter_value,
  input  wire logic              ch1_count_pulse,
  input  wire logic              ch0_pin_a_in,
  input  wire logic              ch0_pin_c_in,
  output logic                   ch0_pin_a_out,
  output logic                   ch0_pin_a_oe,
  output logic                   ch0_pin_c_out,
  output logic                   ch0_pin_c_oe,
  output logic                   capture_a_pulse,
  output logic                   capture_c_pulse,
  output logic                   match_a_pulse,
  output logic                   match_c_pulse
);

  function automatic tmrio_dec_t decode(input logic [FLD_W-1:0] f);
    tmrio_dec_t d;
    d = '0;
    if (!f[FLD_BIT3]) begin
      d.is_out = 1'b1;
      d.oe     = f[FLD_BIT1] | f[FLD_BIT0];
      d.init   = f[FLD_BIT2];
      d.act    = tmrio_act_t'(f[FLD_BIT1:FLD_BIT0]);
    end else if (!f[FLD_BIT2]) begin
      // Pin source, edge select
      d.cap_rise = f[FLD_BIT1] | ~f[FLD_BIT0];
      d.cap_fall = f[FLD_BIT1] | f[FLD_BIT0];
    end else begin
      d.cap_ch1 = 1'b1;
    end
    return d;
  endfunction

  function automatic logic apply_act(input tmrio_act_t a, input logic lvl);
    logic r;
    r = lvl;
    case (a)
      TMRIO_ACT_LOW:    r = 1'b0;
      TMRIO_ACT_HIGH:   r = 1'b1;
      TMRIO_ACT_TOGGLE: r = ~lvl;
      default:          r = lvl;
    endcase
    return r;
  endfunction

  logic [CTRL_W-1:0] ctrl_high;
  logic [CTRL_W-1:0] ctrl_low;
  logic [CTRL_W-1:0] mode_reg;
  logic [CNT_W-1:0]  gen_a;
  logic [CNT_W-1:0]  gen_c;
  logic              a_s1;
  logic              a_s2;
  logic              a_s3;
  logic              c_s1;
  logic              c_s2;
  logic              c_s3;
  logic              eq_a_q;
  logic              eq_c_q;

  logic [CTRL_W-1:0] next_ctrl_high;
  logic [CTRL_W-1:0] next_ctrl_low;
  logic [CTRL_W-1:0] next_mode_reg;
  logic [CNT_W-1:0]  next_gen_a;
  logic [CNT_W-1:0]  next_gen_c;
  logic [DATA_W-1:0] next_prdata;
  logic              next_pready;
  logic              next_pslverr;
  logic              next_pin_a_out;
  logic              next_pin_a_oe;
  logic              next_pin_c_out;
  logic              next_pin_c_oe;

  tmrio_dec_t        dec_a;
  tmrio_dec_t        dec_c;
  tmrio_dec_t        dec_wr;
  logic              buf_en;
  logic              wr_en;
  logic              ld_a;
  logic              ld_c;
  logic              rise_a;
  logic              fall_a;
  logic              rise_c;
  logic              fall_c;
  logic              eq_a;
  logic              eq_c;
  logic              cmp_a;
  logic              cmp_c;
  logic              cap_a;
  logic              cap_c;
  logic              addr_hit;
  logic [DATA_W-1:0] rd_val;

  assign dec_a  = decode(ctrl_high[FLD_W-1:0]);
  assign dec_c  = decode(ctrl_low[FLD_W-1:0]);
  assign buf_en = mode_reg[BUF_A_BIT];
  // Field being written, so enable and level switch in one edge
  assign dec_wr = decode(apb.pwdata[FLD_W-1:0]);

  // Edges read only the second and third flops
  assign rise_a = a_s2 & ~a_s3;
  assign fall_a = ~a_s2 & a_s3;
  assign rise_c = c_s2 & ~c_s3;
  assign fall_c = ~c_s2 & c_s3;

  // Match on the first cycle of equality, so a stalled counter
  // does not re-fire the action every clock
  assign eq_a  = (counter_value == gen_a);
  assign eq_c  = (counter_value == gen_c);
  assign cmp_a = dec_a.is_out & eq_a & ~eq_a_q;
  // no compare on C while it buffers
  assign cmp_c = dec_c.is_out & eq_c & ~eq_c_q & ~buf_en;

  // field A pin capture uses pin A
  // both edges when both selects set
  assign cap_a = (dec_a.cap_rise & rise_a) | (dec_a.cap_fall & fall_a)
               | (dec_a.cap_ch1 & ch1_count_pulse);
  assign cap_c = ~buf_en & ((dec_c.cap_rise & rise_c)
               | (dec_c.cap_fall & fall_c)
               | (dec_c.cap_ch1 & ch1_count_pulse));

  // Write is taken on the edge that completes the access phase
  assign wr_en = apb.psel & apb.penable & pready & apb.pwrite;
  assign ld_a  = wr_en & (apb.paddr == OFS_CTRL_HIGH);
  assign ld_c  = wr_en & (apb.paddr == OFS_CTRL_LOW);

  always_comb begin
    addr_hit = 1'b1;
    rd_val   = '0;
    if (apb.paddr == OFS_CTRL_HIGH) begin
      rd_val[CTRL_W-1:0] = ctrl_high;
    end else if (apb.paddr == OFS_CTRL_LOW) begin
      rd_val[CTRL_W-1:0] = ctrl_low;
    end else if (apb.paddr == OFS_MODE_REG) begin
      rd_val[CTRL_W-1:0] = mode_reg;
    end else if (apb.paddr == OFS_GEN_A) begin
      rd_val[CNT_W-1:0] = gen_a;
    end else if (apb.paddr == OFS_GEN_C) begin
      rd_val[CNT_W-1:0] = gen_c;
    end else if (apb.paddr == OFS_STATUS) begin
      rd_val[ST_A_OUT] = ch0_pin_a_out;
      rd_val[ST_A_OE]  = ch0_pin_a_oe;
      rd_val[ST_C_OUT] = ch0_pin_c_out;
      rd_val[ST_C_OE]  = ch0_pin_c_oe;
      rd_val[ST_A_LVL] = a_s2;
      rd_val[ST_C_LVL] = c_s2;
    end else begin
      addr_hit = 1'b0;
    end
  end

  // Bus answer: zero wait states, ready in the first access cycle
  always_comb begin
    next_pready  = apb.psel & ~apb.penable;
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (apb.psel & ~apb.penable) begin
      next_prdata  = apb.pwrite ? '0 : rd_val;
      next_pslverr = ~addr_hit;
    end
  end

  always_comb begin
    next_ctrl_high = ctrl_high;
    next_ctrl_low  = ctrl_low;
    next_mode_reg  = mode_reg;
    next_gen_a     = gen_a;
    next_gen_c     = gen_c;
    if (wr_en) begin
      if (apb.paddr == OFS_CTRL_HIGH) begin
        next_ctrl_high = apb.pwdata[CTRL_W-1:0];
      end else if (apb.paddr == OFS_CTRL_LOW) begin
        next_ctrl_low = apb.pwdata[CTRL_W-1:0];
      end else if (apb.paddr == OFS_MODE_REG) begin
        next_mode_reg = apb.pwdata[CTRL_W-1:0];
      end else if (apb.paddr == OFS_GEN_A) begin
        next_gen_a = apb.pwdata[CNT_W-1:0];
      end else if (apb.paddr == OFS_GEN_C) begin
        next_gen_c = apb.pwdata[CNT_W-1:0];
      end
    end
    // Capture beats a software write in the same cycle
    if (cap_a) begin
      next_gen_a = counter_value;
    end
    if (cap_c) begin
      next_gen_c = counter_value;
    end
  end

  always_comb begin
    next_pin_a_out = ch0_pin_a_out;
    next_pin_c_out = ch0_pin_c_out;
    next_pin_a_oe  = dec_a.oe;
    next_pin_c_oe  = dec_c.oe & ~buf_en;
    // toggle or fixed level on match
    if (cmp_a) begin
      next_pin_a_out = apply_act(dec_a.act, ch0_pin_a_out);
    end
    if (cmp_c) begin
      next_pin_c_out = apply_act(dec_c.act, ch0_pin_c_out);
    end
    // initial level loaded with the new field
    // enable follows the new field with the level
    if (ld_a) begin
      next_pin_a_out = apb.pwdata[FLD_BIT2];
      next_pin_a_oe  = dec_wr.oe;
    end
    if (ld_c) begin
      next_pin_c_out = apb.pwdata[FLD_BIT2];
      next_pin_c_oe  = dec_wr.oe & ~buf_en;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_high       <= CTRL_RST;
      ctrl_low        <= CTRL_RST;
      mode_reg        <= MODE_RST;
      gen_a           <= GEN_RST;
      gen_c           <= GEN_RST;
      prdata          <= '0;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
      ch0_pin_a_out   <= 1'b0;
      ch0_pin_a_oe    <= 1'b0;
      ch0_pin_c_out   <= 1'b0;
      ch0_pin_c_oe    <= 1'b0;
      capture_a_pulse <= 1'b0;
      capture_c_pulse <= 1'b0;
      match_a_pulse   <= 1'b0;
      match_c_pulse   <= 1'b0;
      a_s1            <= 1'b0;
      a_s2            <= 1'b0;
      a_s3            <= 1'b0;
      c_s1            <= 1'b0;
      c_s2            <= 1'b0;
      c_s3            <= 1'b0;
      eq_a_q          <= 1'b1;
      eq_c_q          <= 1'b1;
    end else begin
      ctrl_high       <= next_ctrl_high;
      ctrl_low        <= next_ctrl_low;
      mode_reg        <= next_mode_reg;
      gen_a           <= next_gen_a;
      gen_c           <= next_gen_c;
      prdata          <= next_prdata;
      pready          <= next_pready;
      pslverr         <= next_pslverr;
      ch0_pin_a_out   <= next_pin_a_out;
      ch0_pin_a_oe    <= next_pin_a_oe;
      ch0_pin_c_out   <= next_pin_c_out;
      ch0_pin_c_oe    <= next_pin_c_oe;
      capture_a_pulse <= cap_a;
      capture_c_pulse <= cap_c;
      match_a_pulse   <= cmp_a;
      match_c_pulse   <= cmp_c;
      a_s1            <= ch0_pin_a_in;
      a_s2            <= a_s1;
      a_s3            <= a_s2;
      c_s1            <= ch0_pin_c_in;
      c_s2            <= c_s1;
      c_s3            <= c_s2;
      eq_a_q          <= eq_a;
      eq_c_q          <= eq_c;
    end
  end

  a_toggle_on_match: assert property (
    @(posedge sys_clk) disable iff (rst)
    (cmp_a && dec_a.act == TMRIO_ACT_TOGGLE && !ld_a)
      |=> (ch0_pin_a_out != $past(ch0_pin_a_out)) && match_a_pulse)
    else $error("pin A did not toggle on match");

  a_off_no_drive: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ctrl_high[FLD_W-1:0] == MODE_OFF_LO) [*2] |-> !ch0_pin_a_oe)
    else $error("pin A driven while output disabled");

  a_low_on_match: assert property (
    @(posedge sys_clk) disable iff (rst)
    (cmp_c && dec_c.act == TMRIO_ACT_LOW && !ld_c) |=> !ch0_pin_c_out)
    else $error("pin C not low after match");

  a_high_on_match: assert property (
    @(posedge sys_clk) disable iff (rst)
    (cmp_a && dec_a.act == TMRIO_ACT_HIGH && !ld_a) |=> ch0_pin_a_out)
    else $error("pin A not high after match");

  a_rise_capture: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ctrl_high[FLD_W-1:0] == MODE_CAP_RISE && a_s2 && !a_s3)
      |=> capture_a_pulse && gen_a == $past(counter_value))
    else $error("rising edge did not capture into A");

  a_fall_capture: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ctrl_high[FLD_W-1:0] == MODE_CAP_FALL && !a_s2 && a_s3)
      |=> capture_a_pulse && gen_a == $past(counter_value))
    else $error("falling edge did not capture into A");

  a_both_edges: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ctrl_low[FLD_BIT3:FLD_BIT1] == 3'h5 && !buf_en && (c_s2 != c_s3))
      |=> capture_c_pulse && gen_c == $past(counter_value))
    else $error("edge of pin C missed in both-edge mode");

  a_ch1_capture: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ctrl_high[FLD_BIT3:FLD_BIT2] == 2'h3 && ch1_count_pulse)
      |=> capture_a_pulse ##0 gen_a == $past(counter_value))
    else $error("channel 1 count did not capture");

  a_buffer_blocks_c: assert property (
    @(posedge sys_clk) disable iff (rst)
    buf_en |=> !capture_c_pulse && !match_c_pulse && !ch0_pin_c_oe)
    else $error("register C active while buffering");

  a_field_next_cycle: assert property (
    @(posedge sys_clk) disable iff (rst)
    ld_a |=> ctrl_high == $past(apb.pwdata[CTRL_W-1:0])
      && ch0_pin_a_out == $past(apb.pwdata[FLD_BIT2]))
    else $error("new field A not applied next cycle");

endmodule

// File: rtl/tmrio_pkg.sv
package tmrio_pkg;

  localparam int CNT_W  = 16;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL_HIGH = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL_LOW  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MODE_REG  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_GEN_A     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_GEN_C     = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h14;

  // Field layout
  localparam int CTRL_W      = 8;
  localparam int FLD_W       = 4;
  localparam int FLD_BIT3    = 3;
  localparam int FLD_BIT2    = 2;
  localparam int FLD_BIT1    = 1;
  localparam int FLD_BIT0    = 0;
  localparam int BUF_A_BIT   = 4;
  localparam int ST_A_OUT    = 0;
  localparam int ST_A_OE     = 1;
  localparam int ST_C_OUT    = 2;
  localparam int ST_C_OE     = 3;
  localparam int ST_A_LVL    = 4;
  localparam int ST_C_LVL    = 5;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST  = 8'h00;
  localparam logic [CTRL_W-1:0] MODE_RST  = 8'h00;
  localparam logic [CNT_W-1:0]  GEN_RST   = 16'hFFFF;

  // Mode codes named by the tests
  localparam logic [FLD_W-1:0] MODE_OFF_LO   = 4'h0;
  localparam logic [FLD_W-1:0] MODE_CAP_RISE = 4'h8;
  localparam logic [FLD_W-1:0] MODE_CAP_FALL = 4'h9;

  typedef enum logic [1:0] {
    TMRIO_ACT_NONE   = 2'h0,
    TMRIO_ACT_LOW    = 2'h1,
    TMRIO_ACT_HIGH   = 2'h2,
    TMRIO_ACT_TOGGLE = 2'h3
  } tmrio_act_t;

  typedef struct packed {
    logic       is_out;
    logic       oe;
    logic       init;
    tmrio_act_t act;
    logic       cap_rise;
    logic       cap_fall;
    logic       cap_ch1;
  } tmrio_dec_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } tmrio_apb_req_t;

endpackage

// File: verification/tmrio_far.sv
module tmrio_far
  import tmrio_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ext_a,
  input  wire logic             ext_c,
  input  wire logic             step_req,
  input  wire logic             a_out,
  input  wire logic             a_oe,
  input  wire logic             c_out,
  input  wire logic             c_oe,
  output logic [CNT_W-1:0]      counter_value,
  output logic                  ch1_count_pulse,
  output logic                  pin_a_in,
  output logic                  pin_c_in
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [CNT_W-1:0] next_counter;

  always_comb begin
    next_counter = counter_value + 16'h0001;
  end

  // Free-running count; one pulse per channel 1 count step
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      counter_value   <= 16'h0000;
      ch1_count_pulse <= 1'b0;
    end else begin
      counter_value   <= next_counter;
      ch1_count_pulse <= step_req;
    end
  end

  // Chip's driver wins the wire; else the outside source
  assign pin_a_in = a_oe ? a_out : ext_a;
  assign pin_c_in = c_oe ? c_out : ext_c;
endmodule

// File: verification/tb_timer_ch0_io_mode_select.sv
module tb_timer_ch0_io_mode_select
  import tmrio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic           sys_clk = 1'b0;
  logic           rst = 1'b1;
  tmrio_apb_req_t apb = '0;
  logic [31:0]    prdata;
  logic           pready, pslverr, c1p, pa, pc;
  logic [15:0]    cnt, tgt;
  logic           a_out, a_oe, c_out, c_oe;
  logic           cap_a, cap_c, mat_a, mat_c;
  logic           ext_a = 1'b0;
  logic           ext_c = 1'b0;
  logic           step_req = 1'b0;
  logic [3:0]     pv;
  logic [3:0]     code;
  bit             got;
  int             n_mismatch = 0;
  int             cmp_count = 0;

  assign pv = {mat_c, mat_a, cap_c, cap_a};
  always #4 sys_clk = ~sys_clk;

  tmrio_ch0 tmrio_ch0_inst (
    .sys_clk(sys_clk), .rst(rst), .apb(apb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .counter_value(cnt),
    .ch1_count_pulse(c1p), .ch0_pin_a_in(pa), .ch0_pin_c_in(pc),
    .ch0_pin_a_out(a_out), .ch0_pin_a_oe(a_oe), .ch0_pin_c_out(c_out),
    .ch0_pin_c_oe(c_oe), .capture_a_pulse(cap_a),
    .capture_c_pulse(cap_c), .match_a_pulse(mat_a),
    .match_c_pulse(mat_c));

  tmrio_far tmrio_far_inst (
    .sys_clk(sys_clk), .rst(rst), .ext_a(ext_a), .ext_c(ext_c),
    .step_req(step_req), .a_out(a_out), .a_oe(a_oe), .c_out(c_out),
    .c_oe(c_oe), .counter_value(cnt), .ch1_count_pulse(c1p),
    .pin_a_in(pa), .pin_c_in(pc));

  task print_verdict;
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task chk(logic [32:0] g, logic [32:0] e, string m);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h", $time, m, g);
    end
  endtask

  // One APB transfer; holds the request until pready is seen
  task xfer(logic w, logic [7:0] a, logic [31:0] d,
            output logic [31:0] r, output logic e);
    int i;
    @(posedge sys_clk);
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    apb.penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    apb <= '0;
    if (i == 16) begin
      chk(0, 1, "bus hang");
      print_verdict;
    end
  endtask

  task wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
    chk(e, 0, "write error");
  endtask

  task rdchk(logic [7:0] a, logic [31:0] x, string m);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h0, r, e);
    chk({e, r}, {1'b0, x}, m);
  endtask

  task wait_p(int s, int lim, output bit g);
    g = 0;
    repeat (lim) begin
      @(negedge sys_clk);
      if (pv[s] === 1'b1) begin
        g = 1;
        break;
      end
    end
  endtask

  // Event on side s: k 0 fall, 1 rise, 2 channel 1 count step
  task ev(int s, int k, bit x);
    logic [15:0] v;
    @(posedge sys_clk);
    if (k == 2) step_req <= 1'b1;
    else if (s == 0) ext_a <= k[0];
    else ext_c <= k[0];
    if (k == 2) @(posedge sys_clk);
    step_req <= 1'b0;
    wait_p(s, 8, got);
    v = cnt - 16'h0001;
    chk(got, x, "capture pulse");
    if (got && !x) print_verdict;
    if (got) rdchk(s ? OFS_GEN_C : OFS_GEN_A, {16'h0, v}, "capture");
  endtask

  task t_reset;
    logic [31:0] r;
    logic e;
    chk({a_oe, c_oe}, 0, "oe at reset");
    rdchk(OFS_CTRL_HIGH, 32'h0, "ctrl high reset");
    rdchk(OFS_CTRL_LOW, 32'h0, "ctrl low reset");
    rdchk(OFS_MODE_REG, 32'h0, "mode reset");
    rdchk(OFS_GEN_A, 32'hFFFF, "gen a reset");
    rdchk(OFS_GEN_C, 32'hFFFF, "gen c reset");
    xfer(1'b0, 8'h18, 32'h0, r, e);
    chk({e, r}, {1'b1, 32'h0}, "unmapped read");
  endtask

  task t_compare;
    logic x;
    for (int i = 0; i < 8; i++) begin
      code = i[3:0];
      wr(OFS_CTRL_HIGH, {28'h0, code});
      @(negedge sys_clk);
      chk(a_oe, code[1:0] != 2'b00, "oe");
      chk(a_out, code[2], "initial level");
      tgt = cnt + 16'h0018;
      wr(OFS_GEN_A, {16'h0, tgt});
      wait_p(2, 40, got);
      x = code[1:0] == 2'h1 ? 1'b0 : code[1:0] == 2'h2 ? 1'b1 : ~code[2];
      if (code[1:0] != 2'b00) chk(got, 1, "match");
      chk(a_out, code[1:0] != 2'b00 ? x : code[2], "match level");
    end
  endtask

  task t_capture;
    wr(OFS_CTRL_HIGH, 32'h0);
    for (int i = 8; i < 16; i++) begin
      code = i[3:0];
      wr(OFS_CTRL_HIGH, {28'h0, code});
      ev(0, 1, code == 4'h8 || code[3:1] == 3'b101);
      ev(0, 0, code == 4'h9 || code[3:1] == 3'b101);
      ev(0, 2, code[2]);
    end
  endtask

  task t_buffer;
    wr(OFS_CTRL_LOW, 32'h5);
    @(negedge sys_clk);
    chk({c_oe, c_out}, 2'b11, "c initial");
    tgt = cnt + 16'h0018;
    wr(OFS_GEN_C, {16'h0, tgt});
    wait_p(3, 40, got);
    chk({got, c_out}, 2'b10, "c match");
    wr(OFS_CTRL_LOW, 32'h8);
    ev(1, 1, 1);
    ev(1, 0, 0);
    wr(OFS_CTRL_LOW, 32'hB);
    ev(1, 1, 1);
    ev(1, 0, 1);
    wr(OFS_MODE_REG, 32'h10);
    ev(1, 1, 0);
    wr(OFS_CTRL_LOW, 32'hC);
    ev(1, 2, 0);
    wr(OFS_CTRL_LOW, 32'h3);
    @(negedge sys_clk);
    chk(c_oe, 0, "buffered c oe");
    tgt = cnt + 16'h0018;
    wr(OFS_GEN_C, {16'h0, tgt});
    wait_p(3, 40, got);
    chk(got, 0, "buffered c match");
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    chk(0, 1, "watchdog");
    print_verdict;
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    t_compare;
    t_capture;
    t_buffer;
    print_verdict;
  end
endmodule
